// *** hw/has_cfg.svh ***
// Offsets, fields and timing counts of the host access sequencer
`ifndef HAS_CFG_SVH
`define HAS_CFG_SVH
// Device registers (outside map)
`define HAS_DEV_MEM_DATA     8'h02
`define HAS_DEV_SYS_CONFIG   8'h10
`define HAS_DEV_INT_ENABLE   8'hF0
`define HAS_DEV_INT_FLAGS    8'hF1
`define HAS_COLOR_LSB        2
`define HAS_COLOR_MSB        3
// Pixel fields of a 65K word
`define HAS_RED_MSB          15
`define HAS_RED_LSB          11
`define HAS_GRN_MSB          10
`define HAS_GRN_LSB          5
`define HAS_BLU_MSB          4
`define HAS_BLU_LSB          0
// Own APB registers (byte addresses)
`define HAS_REG_CTRL         12'h000
`define HAS_REG_ADDR         12'h004
`define HAS_REG_WDATA        12'h008
`define HAS_REG_RDATA        12'h00C
`define HAS_REG_STATUS       12'h010
`define HAS_REG_PIXEL        12'h014
// Control fields
`define HAS_CTRL_GO          0
`define HAS_CTRL_OP_LSB      1
`define HAS_CTRL_OP_MSB      3
`define HAS_CTRL_WAITCHK     4
// Status fields
`define HAS_ST_BUSY          0
`define HAS_ST_DONE          1
`define HAS_ST_INT           2
`define HAS_ST_WAIT          3
`define HAS_ST_MODE_LSB      4
`define HAS_ST_MODE_MSB      5
`define HAS_ST_REFUSED       6
// Bus cycle timing, 50 MHz clock
`define HAS_CLK_NS           20
`define HAS_STROBE_NS        20
`define HAS_CYCLE_NS         50
`define HAS_GAP_CLKS         4
`define HAS_STROBE_CYC       ((`HAS_STROBE_NS + `HAS_CLK_NS - 1) / `HAS_CLK_NS)
`define HAS_CYCLE_CYC        ((`HAS_CYCLE_NS + `HAS_CLK_NS - 1) / `HAS_CLK_NS)
// Spacing of data writes must exceed four device clocks; host clock assumed no faster
`define HAS_SPACE_CYC        (`HAS_GAP_CLKS + 1)
`endif

// *** hw/has_cycle.sv ***
// One parallel bus cycle toward the device
`include "has_cfg.svh"
`default_nettype none
module has_cycle
  import has_pkg::*;
(
  input  wire logic        clk,       // System clock
  input  wire logic        sys_rst,   // Sync reset
  input  wire logic        clk_en,    // Freeze when low
  input  wire has_cyc_t    req,       // Cycle order
  input  wire logic [15:0] din,       // Data from device
  output var  has_pins_t   pins,      // Pin drive
  output var  logic [15:0] rdata,     // Captured read data
  output logic             done       // Cycle ended, pulse
);
  typedef struct packed {
    has_state_t  st;
    logic [3:0]  cnt;
    logic        sel;
    logic        rd;
    logic [15:0] data;
    logic [15:0] cap;
    logic        done;
  } has_cst_t;

  has_cst_t cur;
  has_cst_t next_cur;

  // Cycle phases: setup, strobe, hold, spacing
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    case (cur.st)
      HAS_S_IDLE: begin
        if (req.go) begin
          next_cur.sel = req.sel;
          next_cur.rd = req.rd;
          next_cur.data = req.data;
          next_cur.st = HAS_S_SETUP;
        end
      end
      HAS_S_SETUP: begin
        next_cur.cnt = 4'(`HAS_STROBE_CYC);
        next_cur.st = HAS_S_STRB;
      end
      HAS_S_STRB: begin
        if (cur.cnt <= 4'h1) begin
          if (cur.rd) begin
            next_cur.cap = din; // Sample at strobe end
          end
          next_cur.st = HAS_S_HOLD;
        end else begin
          next_cur.cnt = cur.cnt - 4'h1;
        end
      end
      HAS_S_HOLD: begin
        next_cur.cnt = 4'(`HAS_SPACE_CYC);
        next_cur.st = HAS_S_GAP;
      end
      HAS_S_GAP: begin
        if (cur.cnt <= 4'h1) begin
          next_cur.done = 1'b1;
          next_cur.st = HAS_S_IDLE;
        end else begin
          next_cur.cnt = cur.cnt - 4'h1;
        end
      end
      default: begin
        next_cur.st = HAS_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '{st: HAS_S_IDLE, cnt: 4'h0, sel: 1'b0, rd: 1'b0,
               data: 16'h0000, cap: 16'h0000, done: 1'b0};
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  // Pin levels follow the phase; high select marks command or status
  always_comb begin
    pins.cs_n = !(cur.st == HAS_S_SETUP || cur.st == HAS_S_STRB || cur.st == HAS_S_HOLD);
    pins.cycle_select = cur.sel;
    pins.wr_n = !(cur.st == HAS_S_STRB && !cur.rd);
    pins.rd_n = !(cur.st == HAS_S_STRB && cur.rd);
    pins.dout = cur.data;
    pins.doe = !cur.rd && !pins.cs_n;
  end

  assign rdata = cur.cap;
  assign done = cur.done;
endmodule : has_cycle
`default_nettype wire

// *** hw/has_host.sv ***
// Host controller that drives the display device over its parallel port
// How it works
// - Register write is a command cycle with address, then a data write cycle.
// - Register read is a command cycle with address, then a data read cycle.
// - In memory mode data cycles repeat without a new 02h command.
// - Reads and writes are never mixed within one memory session.
// - First read after entering memory mode is a dummy, discarded.
// - Flags stay set until the host writes one to clear them.
// - Host does not touch memory during a block transfer move.
// - Device needs one clock to latch a command; check busy. Command pairs send their data cycle without reading wait_n.
// - Memory writes during busy are lost; host checks busy first.
// - 65K pixel word: red 15..11, green 10..5, blue 4..0.
// - Cycle select high is command or status, low is data.
// - Data write cycles spaced more than four device clocks apart.
//
// Implementation choice: the APB register port.
`include "has_cfg.svh"
`default_nettype none
module has_host
  import has_pkg::*;
(
  input  wire logic        clk,         // System clock
  input  wire logic        sys_rst,     // Sync reset, high
  input  wire logic        clk_en,      // Freeze when low
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB enable
  input  wire logic        pwrite,      // APB direction
  input  wire logic [11:0] paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic             pready,      // APB ready
  output var  logic [31:0] prdata,      // APB read data
  output logic             pslverr,     // APB error
  output logic             cs_n,        // Device chip select
  output logic             cycle_select,// High command, low data
  output logic             wr_n,        // Write strobe
  output logic             rd_n,        // Read strobe
  output logic [15:0]      dbus_out,    // Data bus drive
  output logic             dbus_oe,     // Data bus enable
  input  wire logic [15:0] dbus_in,     // Data bus sense
  input  wire logic        int_n,       // Device interrupt, low
  input  wire logic        wait_n       // Device busy, low
);
  // Controller state as one struct
  typedef struct packed {
    logic        busy;
    logic        done;
    logic        refused;
    logic        phase2;   // Second cycle of a pair pending
    logic        dummy;    // Current read is the dummy
    logic        inflight; // Engine owns a cycle
    has_op_t     op;
    logic        waitchk;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    has_msess_t  ms;
    has_cyc_t    cyc;
  } has_hst_t;

  has_hst_t  cur;
  has_hst_t  next_cur;
  has_pins_t pins;
  logic [15:0] cyc_rdata;
  logic        cyc_done;
  logic        wr_acc;
  logic        rd_acc;
  logic [31:0] next_prdata;
  logic        u_idle;

  // Decode of an APB address, used in both access paths
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
    addr_hit = (a == r);
  endfunction : addr_hit

  // Pack colour channels into the 65K pixel word
  function automatic logic [15:0] pack565(input logic [31:0] v);
    pack565 = {v[20:16], v[13:8], v[4:0]};
  endfunction : pack565

  has_cycle u_cycle (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .req     (cur.cyc),
    .din     (dbus_in),
    .pins    (pins),
    .rdata   (cyc_rdata),
    .done    (cyc_done)
  );

  // Zero-wait slave; every access answers in the access phase
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite && clk_en;
  assign rd_acc = psel && penable && !pwrite;
  assign pslverr = psel && penable &&
                   !(addr_hit(paddr, `HAS_REG_CTRL) || addr_hit(paddr, `HAS_REG_ADDR) ||
                     addr_hit(paddr, `HAS_REG_WDATA) || addr_hit(paddr, `HAS_REG_RDATA) ||
                     addr_hit(paddr, `HAS_REG_STATUS) || addr_hit(paddr, `HAS_REG_PIXEL));

  // Orders, sequencing of cycle pairs and memory sessions
  always_comb begin
    next_cur = cur;
    next_cur.cyc.go = 1'b0;
    if (wr_acc && addr_hit(paddr, `HAS_REG_ADDR)) begin
      next_cur.addr = pwdata[7:0];
    end
    if (wr_acc && addr_hit(paddr, `HAS_REG_WDATA)) begin
      next_cur.wdata = pwdata[15:0];
    end
    if (wr_acc && addr_hit(paddr, `HAS_REG_PIXEL)) begin
      next_cur.wdata = pack565(pwdata);
    end
    // Start a new order; done flag is cleared by the start
    if (wr_acc && addr_hit(paddr, `HAS_REG_CTRL) && pwdata[`HAS_CTRL_GO] && !cur.busy) begin
      next_cur.op = has_op_t'(pwdata[`HAS_CTRL_OP_MSB:`HAS_CTRL_OP_LSB]);
      next_cur.waitchk = pwdata[`HAS_CTRL_WAITCHK];
      next_cur.done = 1'b0;
      next_cur.refused = 1'b0;
      next_cur.busy = 1'b1;
      next_cur.phase2 = 1'b0;
      next_cur.dummy = 1'b0;
    end
    // Issue a cycle once the engine is free
    if (cur.busy && !cur.cyc.go && !cyc_done && u_idle) begin
      case (cur.op)
        HAS_OP_REG_WR, HAS_OP_REG_RD, HAS_OP_MEM_ENT: begin
          if (!cur.phase2) begin
            next_cur.cyc = '{go: 1'b1, sel: 1'b1, rd: 1'b0,
                             data: {8'h00, (cur.op == HAS_OP_MEM_ENT) ?
                                    `HAS_DEV_MEM_DATA : cur.addr}};
          end else begin
            next_cur.cyc = '{go: 1'b1, sel: 1'b0, rd: (cur.op == HAS_OP_REG_RD),
                             data: cur.wdata};
          end
        end
        HAS_OP_MEM_WR: begin
          // Memory writes wait out device busy so data is not lost
          if (cur.ms == HAS_MS_RD) begin
            next_cur.refused = 1'b1;
            next_cur.busy = 1'b0;
            next_cur.done = 1'b1;
          end else if (wait_n || !cur.waitchk) begin
            next_cur.cyc = '{go: 1'b1, sel: 1'b0, rd: 1'b0, data: cur.wdata};
          end
        end
        HAS_OP_MEM_RD: begin
          if (cur.ms == HAS_MS_WR) begin
            next_cur.refused = 1'b1;
            next_cur.busy = 1'b0;
            next_cur.done = 1'b1;
          end else if (wait_n || !cur.waitchk) begin
            next_cur.dummy = (cur.ms != HAS_MS_RD) && !cur.phase2;
            next_cur.cyc = '{go: 1'b1, sel: 1'b0, rd: 1'b1, data: 16'h0000};
          end
        end
        HAS_OP_STATUS: begin
          next_cur.cyc = '{go: 1'b1, sel: 1'b1, rd: 1'b1, data: 16'h0000};
        end
        default: begin
          next_cur.busy = 1'b0;
          next_cur.done = 1'b1;
          next_cur.refused = 1'b1;
        end
      endcase
      if (next_cur.cyc.go) begin
        next_cur.inflight = 1'b1;
      end
    end
    // End of a bus cycle
    if (cyc_done) begin
      next_cur.inflight = 1'b0;
      case (cur.op)
        HAS_OP_REG_WR, HAS_OP_REG_RD: begin
          if (!cur.phase2) begin
            next_cur.phase2 = 1'b1;
            next_cur.ms = HAS_MS_NONE; // Any other command leaves memory mode
          end else begin
            if (cur.op == HAS_OP_REG_RD) begin
              next_cur.rdata = cyc_rdata;
            end
            next_cur.busy = 1'b0;
            next_cur.done = 1'b1;
          end
        end
        HAS_OP_MEM_ENT: begin
          next_cur.ms = HAS_MS_IDLE;
          next_cur.busy = 1'b0;
          next_cur.done = 1'b1;
        end
        HAS_OP_MEM_WR: begin
          next_cur.ms = HAS_MS_WR;
          next_cur.busy = 1'b0;
          next_cur.done = 1'b1;
        end
        HAS_OP_MEM_RD: begin
          next_cur.ms = HAS_MS_RD;
          if (cur.dummy) begin
            next_cur.phase2 = 1'b1; // discard, read again
            next_cur.dummy = 1'b0;
          end else begin
            next_cur.rdata = cyc_rdata;
            next_cur.busy = 1'b0;
            next_cur.done = 1'b1;
          end
        end
        default: begin
          next_cur.rdata = cyc_rdata;
          next_cur.busy = 1'b0;
          next_cur.done = 1'b1;
        end
      endcase
    end
  end

  // Engine counts as free only after its done pulse; cs_n is already high in the gap
  assign u_idle = !cur.inflight && !cyc_done;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '0;
      cur.op <= HAS_OP_REG_WR;
      cur.ms <= HAS_MS_NONE;
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  // Read mux; interrupt and wait pins shown as seen, flags live in the device
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (addr_hit(paddr, `HAS_REG_ADDR)) begin
      next_prdata = {24'h000000, cur.addr};
    end else if (addr_hit(paddr, `HAS_REG_WDATA)) begin
      next_prdata = {16'h0000, cur.wdata};
    end else if (addr_hit(paddr, `HAS_REG_RDATA)) begin
      next_prdata = {16'h0000, cur.rdata};
    end else if (addr_hit(paddr, `HAS_REG_STATUS)) begin
      next_prdata[`HAS_ST_BUSY] = cur.busy;
      next_prdata[`HAS_ST_DONE] = cur.done;
      next_prdata[`HAS_ST_INT] = !int_n;
      next_prdata[`HAS_ST_WAIT] = !wait_n;
      next_prdata[`HAS_ST_MODE_MSB:`HAS_ST_MODE_LSB] = cur.ms;
      next_prdata[`HAS_ST_REFUSED] = cur.refused;
    end else if (addr_hit(paddr, `HAS_REG_CTRL)) begin
      next_prdata = {27'h0000000, cur.waitchk, cur.op, 1'b0};
    end
  end

  // Read data from a flop, loaded in the setup cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !rd_acc) begin
      prdata <= next_prdata;
    end
  end

  assign cs_n = pins.cs_n;
  assign cycle_select = pins.cycle_select;
  assign wr_n = pins.wr_n;
  assign rd_n = pins.rd_n;
  assign dbus_out = pins.dout;
  assign dbus_oe = pins.doe;

  // Read and write strobes are never low together
  a_strobe_excl: assert property (@(posedge clk) disable iff (sys_rst)
    !(!wr_n && !rd_n)) else $error("both strobes low");

  sequence s_cmd_cycle;
    !cs_n && cycle_select && !wr_n;
  endsequence
  sequence s_data_cycle;
    !cs_n && !cycle_select && (!wr_n || !rd_n);
  endsequence
  // Chip select frame: three cycles low, then released
  sequence s_frame;
    !cs_n [*3] ##1 cs_n;
  endsequence

  // A frozen clock enable stretches every window, so freezing aborts the check
  a_reg_pair: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
    (cur.op == HAS_OP_REG_WR) ##0 s_cmd_cycle |-> ##[1:30] s_data_cycle)
    else $error("register command not followed by data");

  a_mem_enter: assert property (@(posedge clk) disable iff (sys_rst)
    (cur.op == HAS_OP_MEM_ENT) ##0 s_cmd_cycle |-> dbus_out[7:0] == `HAS_DEV_MEM_DATA)
    else $error("memory command address wrong");

  a_no_mix: assert property (@(posedge clk) disable iff (sys_rst)
    (cur.ms == HAS_MS_RD) |-> !(!wr_n && !cycle_select))
    else $error("write inside read session");

  a_dummy_read: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(cur.dummy) && clk_en |-> cur.busy)
    else $error("dummy read ended the order");

  a_busy_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (cur.waitchk && !wait_n && cur.busy && cur.op == HAS_OP_MEM_WR && pins.cs_n)
      |=> !(cur.cyc.go)) else $error("memory write issued while busy");

  a_space_wr: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(wr_n) && clk_en |=> wr_n [*4]) else $error("write cycles too close");

  a_rd_dbus_off: assert property (@(posedge clk) disable iff (sys_rst)
    !rd_n |-> !dbus_oe) else $error("bus driven during read");

  a_go_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    cur.cyc.go && clk_en |=> !cur.cyc.go && cur.inflight)
    else $error("cycle order repeated");

  a_wr_width: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(wr_n) && clk_en |=> wr_n) else $error("write strobe too long");

  a_cs_frame: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
    $fell(cs_n) |-> s_frame) else $error("chip select frame wrong");

  a_mix_refused: assert property (@(posedge clk) disable iff (sys_rst)
    cur.busy && cur.op == HAS_OP_MEM_WR && cur.ms == HAS_MS_RD && clk_en
      |=> cur.refused && !cur.busy) else $error("mixed session not refused");

  a_dummy_keep: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_done && cur.dummy && clk_en |=> $stable(cur.rdata))
    else $error("dummy read data taken");

  a_wr_drive: assert property (@(posedge clk) disable iff (sys_rst)
    !wr_n |-> dbus_oe) else $error("write without bus drive");

  a_status_sel: assert property (@(posedge clk) disable iff (sys_rst)
    !rd_n && cur.op == HAS_OP_STATUS |-> cycle_select)
    else $error("status read without select");

  a_busy_done: assert property (@(posedge clk) disable iff (sys_rst)
    cur.busy |-> !cur.done) else $error("done while busy");
endmodule : has_host
`default_nettype wire

// *** hw/has_pkg.sv ***
// Types of the host access sequencer
`default_nettype none
package has_pkg;
  // Operations that software orders
  typedef enum logic [2:0] {
    HAS_OP_REG_WR  = 3'h0,
    HAS_OP_REG_RD  = 3'h1,
    HAS_OP_MEM_ENT = 3'h2,
    HAS_OP_MEM_WR  = 3'h3,
    HAS_OP_MEM_RD  = 3'h4,
    HAS_OP_STATUS  = 3'h5
  } has_op_t;
  // Memory session direction
  typedef enum logic [1:0] {
    HAS_MS_NONE = 2'h0,
    HAS_MS_WR   = 2'h1,
    HAS_MS_RD   = 2'h2,
    HAS_MS_IDLE = 2'h3
  } has_msess_t;
  // Bus cycle phases, one-hot
  typedef enum logic [5:0] {
    HAS_S_IDLE  = 6'h01,
    HAS_S_WAIT  = 6'h02,
    HAS_S_SETUP = 6'h04,
    HAS_S_STRB  = 6'h08,
    HAS_S_HOLD  = 6'h10,
    HAS_S_GAP   = 6'h20
  } has_state_t;
  // Pins toward the device
  typedef struct packed {
    logic        cs_n;
    logic        cycle_select;
    logic        wr_n;
    logic        rd_n;
    logic [15:0] dout;
    logic        doe;
  } has_pins_t;
  // One bus cycle order to the cycle engine
  typedef struct packed {
    logic        go;
    logic        sel;
    logic        rd;
    logic [15:0] data;
  } has_cyc_t;
endpackage : has_pkg
`default_nettype wire

// *** testbench/has_dev_model.sv ***
// Behavioural model of the display device behind its parallel host port
`default_nettype none
module has_dev_model
  import has_pkg::*;
(
  input  wire logic        clk,          // System clock
  input  wire logic        sys_rst,      // Sync reset
  input  wire logic        cs_n,         // Chip select, low
  input  wire logic        cycle_select, // High command, low data
  input  wire logic        wr_n,         // Write strobe, low
  input  wire logic        rd_n,         // Read strobe, low
  input  wire logic [15:0] dbus_out,     // Host data drive
  output var  logic [15:0] dev_dq,       // Device data drive
  output var  logic        int_n,        // Interrupt, low
  output var  logic        wait_n,       // Busy, low
  input  wire logic        busy,         // Bench makes device busy
  input  wire logic [4:0]  ev            // Bench event pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  regs [0:255];
  logic [15:0] mem  [0:63];
  logic [7:0]  addr;
  logic [5:0]  wcur, rcur;
  logic        mem_mode, dummy_done;
  logic [15:0] last = 16'h5A5A;
  int          gap, gap_err, lost;
  // Pins: mask gates only the interrupt output
  assign int_n  = ~|(regs[8'hF0][4:0] & regs[8'hF1][4:0]);
  assign wait_n = ~busy;
  // Read data; a released bus shows the inverse of the last value, not a held copy
  always_comb begin
    if (!cs_n && !rd_n && cycle_select) dev_dq = {8'h00, busy, 7'h00};
    else if (!cs_n && !rd_n && !mem_mode) dev_dq = {8'h00, regs[addr]};
    else if (!cs_n && !rd_n) dev_dq = dummy_done ? mem[rcur] : 16'hDEAD;
    else dev_dq = ~last;
  end
  // Cycle decode, register file and memory cursors
  always @(posedge clk) begin
    if (!cs_n && !rd_n) last <= dev_dq;
    if (sys_rst) begin
      {mem_mode, dummy_done, wcur, rcur, addr} <= '0;
      {gap, gap_err, lost} <= {32'd99, 32'd0, 32'd0};
      regs[8'hF0] <= 8'h00;
      regs[8'hF1] <= 8'h00;
    end else begin
      gap <= gap + 1;
      regs[8'hF1][4:0] <= regs[8'hF1][4:0] | ev;
      if (!cs_n && !wr_n && cycle_select) begin
        addr <= dbus_out[7:0];
        mem_mode <= (dbus_out[7:0] == 8'h02);
        dummy_done <= 1'h0;
      end else if (!cs_n && !wr_n) begin
        if (gap < 4) gap_err <= gap_err + 1;
        gap <= 0;
        if (busy) lost <= lost + 1;
        else if (mem_mode) begin
          mem[wcur] <= dbus_out;
          wcur <= wcur + 6'h01;
        end else if (addr == 8'hF1) regs[addr] <= (regs[addr] | ev) & ~dbus_out[7:0];
        else regs[addr] <= dbus_out[7:0];
      end else if (!cs_n && !rd_n && !cycle_select && mem_mode) begin
        if (dummy_done) rcur <= rcur + 6'h01;
        dummy_done <= 1'h1;
      end
    end
  end
endmodule : has_dev_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench of the host controller against the device model
`include "has_cfg.svh"
`default_nettype none
module tb_top
  import has_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, busy = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, r;
  logic        pready, pslverr, cs_n, cycle_select, wr_n, rd_n, dbus_oe, int_n, wait_n;
  logic        last_err;
  logic [15:0] dbus_out, dbus_in, dev_dq;
  logic [15:0] words [0:3];
  logic [7:0]  a, d;
  logic [4:0]  ev = 5'h0;
  integer      seed = 32'hDF0B877C;
  int          bad_count = 0, checks_done = 0;
  // Shared wire: host drive wins while its enable is high
  assign dbus_in = dbus_oe ? dbus_out : dev_dq;
  always #10 clk = ~clk;
  has_host has_host_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cs_n(cs_n), .cycle_select(cycle_select),
    .wr_n(wr_n), .rd_n(rd_n), .dbus_out(dbus_out), .dbus_oe(dbus_oe), .dbus_in(dbus_in),
    .int_n(int_n), .wait_n(wait_n));
  has_dev_model dev_i (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .cycle_select(cycle_select), .wr_n(wr_n), .rd_n(rd_n), .dbus_out(dbus_out),
    .dev_dq(dev_dq), .int_n(int_n), .wait_n(wait_n), .busy(busy), .ev(ev));
  // Verdict and end of run
  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic timeout(input string m);
    $display("wrong value at %0t: %s timed out", $time, m);
    bad_count++;
    stop_test();
  endtask : timeout
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] pack565(input logic [31:0] v);
    return {v[20:16], v[13:8], v[4:0]};
  endfunction : pack565
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) timeout("bus");
    q = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // Poll status until the engine is idle
  task automatic poll();
    int n;
    n = 0;
    do begin
      apb(1'h0, `HAS_REG_STATUS, 32'h0);
      n++;
    end while (q[`HAS_ST_BUSY] !== 1'h0 && n < 40);
    if (n >= 40) timeout("status");
  endtask : poll
  task automatic run(input has_op_t code, input logic wchk);
    apb(1'h1, `HAS_REG_CTRL, {27'h0, wchk, code, 1'h1});
    poll();
  endtask : run
  task automatic op(input has_op_t code, input logic [7:0] ad, input logic [15:0] wd);
    apb(1'h1, `HAS_REG_ADDR, {24'h0, ad});
    apb(1'h1, `HAS_REG_WDATA, {16'h0, wd});
    run(code, 1'h0);
  endtask : op
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    chk(cs_n, 1'h1, "chip select idle");
    chk(dbus_oe, 1'h0, "bus released");
    chk(prdata, 32'h0, "read data reset");
    // Unmapped address answers with an error and zero
    apb(1'h0, 12'hFFC, 32'h0);
    chk(q, 32'h0, "unmapped read");
    chk(last_err, 1'h1, "unmapped error");
    // Random registers, the first one holding the colour-depth field
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      a = (i == 0) ? `HAS_DEV_SYS_CONFIG : 8'h20 + {1'h0, r[6:0]};
      d = r[15:8];
      op(HAS_OP_REG_WR, a, {8'h00, d});
      chk(dev_i.regs[a], d, "register stored");
      op(HAS_OP_REG_RD, a, 16'h0);
      apb(1'h0, `HAS_REG_RDATA, 32'h0);
      chk(q[15:0], {8'h00, d}, "register read");
    end
    // Memory writes in one session, then reads behind the dummy
    op(HAS_OP_MEM_ENT, `HAS_DEV_MEM_DATA, 16'h0);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      words[i] = r[15:0];
      op(HAS_OP_MEM_WR, 8'h00, words[i]);
    end
    op(HAS_OP_MEM_ENT, `HAS_DEV_MEM_DATA, 16'h0);
    for (int i = 0; i < 4; i++) begin
      op(HAS_OP_MEM_RD, 8'h00, 16'h0);
      apb(1'h0, `HAS_REG_RDATA, 32'h0);
      chk(q[15:0], words[i], "memory read");
    end
    // A write inside a read session never reaches the pins
    op(HAS_OP_MEM_WR, 8'h00, 16'h1234);
    chk(q[`HAS_ST_REFUSED], 1'h1, "mixed session refused");
    chk(dev_i.wcur, 6'h04, "write cursor kept");
    // Pixel fields packed into one word
    r = $random(seed);
    op(HAS_OP_MEM_ENT, `HAS_DEV_MEM_DATA, 16'h0);
    apb(1'h1, `HAS_REG_PIXEL, {11'h0, r[20:16], 2'h0, r[13:8], 3'h0, r[4:0]});
    run(HAS_OP_MEM_WR, 1'h0);
    chk(dev_i.mem[4], pack565(r), "pixel packing");
    // Checked write held back while the device is busy
    busy <= 1'h1;
    r = $random(seed);
    apb(1'h1, `HAS_REG_WDATA, {16'h0, r[15:0]});
    apb(1'h1, `HAS_REG_CTRL, {27'h0, 1'h1, HAS_OP_MEM_WR, 1'h1});
    repeat (10) @(posedge clk);
    apb(1'h0, `HAS_REG_STATUS, 32'h0);
    chk(q[`HAS_ST_BUSY], 1'h1, "held while busy");
    chk(q[`HAS_ST_WAIT], 1'h1, "busy pin seen");
    chk(dev_i.lost, 0, "no write while busy");
    busy <= 1'h0;
    poll();
    chk(dev_i.mem[5], r[15:0], "write after busy");
    // Each source flags while masked; enable raises the pin, write one clears
    for (int b = 0; b < 5; b++) begin
      op(HAS_OP_REG_WR, `HAS_DEV_INT_ENABLE, 16'h0);
      @(posedge clk);
      ev <= 5'h1 << b;
      @(posedge clk);
      ev <= 5'h0;
      op(HAS_OP_REG_RD, `HAS_DEV_INT_FLAGS, 16'h0);
      apb(1'h0, `HAS_REG_RDATA, 32'h0);
      chk(q[4:0], 5'h1 << b, "flag set while masked");
      chk(int_n, 1'h1, "masked pin idle");
      op(HAS_OP_REG_WR, `HAS_DEV_INT_ENABLE, 16'h1 << b);
      apb(1'h0, `HAS_REG_STATUS, 32'h0);
      chk(q[`HAS_ST_INT], 1'h1, "enabled flag raises pin");
      op(HAS_OP_REG_WR, `HAS_DEV_INT_FLAGS, 16'h1 << b);
      apb(1'h0, `HAS_REG_STATUS, 32'h0);
      chk(q[`HAS_ST_INT], 1'h0, "cleared flag drops pin");
    end
    // Status order, unknown order code, frozen write
    busy <= 1'h1;
    run(HAS_OP_STATUS, 1'h0);
    busy <= 1'h0;
    apb(1'h0, `HAS_REG_RDATA, 32'h0);
    chk(q[15:0], 16'h0080, "status cycle");
    run(has_op_t'(3'h7), 1'h0);
    chk(q[`HAS_ST_REFUSED], 1'h1, "unknown order");
    clk_en <= 1'h0;
    apb(1'h1, `HAS_REG_ADDR, 32'h5A);
    clk_en <= 1'h1;
    apb(1'h0, `HAS_REG_ADDR, 32'h0);
    chk(q[7:0], `HAS_DEV_INT_FLAGS, "frozen write");
    chk(dev_i.gap_err, 0, "data write spacing");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
